// ---- include/ecfd_pkg.sv ----
// Constants and types for one channel of the edge counter / frequency divider timer.
// Assumes a single clock domain; every control bit arrives as a plain port.
//
// Contract
// [RULE_01] Unit clock disabled: all register writes and reads are blocked; enabling leaves channels stopped.
// [RULE_02] Clearing the unit clock enable stops the unit and resets all registers.
// [RULE_03] Each channel runs from one of two prescaled operating clocks, chosen per channel.
// [RULE_04] Software configures filter, mode, edge and count while the channel is stopped.
// [RULE_05] Start trigger sets enable status and begins; the trigger reads back as zero.
// [RULE_06] Stop trigger clears enable status and halts; the counter holds its value.
// [RULE_07] Event counter: on start, load data value into counter, then await a valid edge.
// [RULE_08] Event counter: decrement per valid edge; at zero reload from data and continue.
// [RULE_09] Event counter: interrupt each time the counter is seen at zero.
// [RULE_10] Software clears output bit, output enable, output mode and level for event counting.
// [RULE_11] While counting, software may rewrite data but not mode or output settings.
// [RULE_12] Data written while counting takes effect only at the next reload.
// [RULE_13] Divider mode is offered on channels 0 and 3 only.
// [RULE_14] Divider: after start, load data into counter on the first valid edge.
// [RULE_15] Divider: start interrupt mode 0 gives no interrupt or toggle at first load; 1 gives both.
// [RULE_16] Divider: decrement per valid edge; at zero toggle output, reload and continue.
// [RULE_17] Divider: each zero detection also raises the interrupt with the toggle.
// [RULE_18] Divided frequency is input over 2(data+1) single edge, about input over data+1 both edges.
// [RULE_19] Output enable 0 drives the output bit level; 1 lets counting toggle the pin.
// [RULE_20] Stopping a divider keeps its output at its current level.
// [RULE_21] After stopping, software clears output enable then writes the output bit.
// [RULE_22] While dividing, software may change output and enable bits but not mode settings.
// [RULE_23] Input is sampled on the operating clock; period error up to one operating clock.
// [RULE_24] When split into two 8-bit halves, only the lower half counts events.
// [RULE_25] Counter and data are 16 bits; edges compare synchronised sample with previous one.
// [RULE_26] Enable status reads 1 from start until stop or unit disable, otherwise 0.

package ecfd_pkg;

  // ****************************************
  // Widths and values
  // ****************************************
  localparam int unsigned ECFD_CNT_W = 16;
  localparam logic [15:0] ECFD_CNT_ZERO = 16'h0000;
  localparam logic [15:0] ECFD_CNT_RST = 16'hffff;
  localparam logic [15:0] ECFD_DATA_RST = 16'h0000;
  localparam logic [7:0] ECFD_HALF_ZERO = 8'h00;
  localparam int unsigned ECFD_PRESC_W = 16;
  localparam logic [15:0] ECFD_PRESC_A_RST = 16'h0000;
  localparam logic [15:0] ECFD_PRESC_B_RST = 16'h0000;

  // ****************************************
  // Edge selection codes
  // ****************************************
  localparam logic [1:0] ECFD_EDGE_FALL = 2'h0;
  localparam logic [1:0] ECFD_EDGE_RISE = 2'h1;
  localparam logic [1:0] ECFD_EDGE_BOTH = 2'h2;

  // Channel operating modes
  typedef enum logic [1:0] {
    ECFD_MODE_EVENT = 2'b00,
    ECFD_MODE_DIVIDE = 2'b01
  } ecfd_mode_e;

  // Channel states
  typedef enum logic [1:0] {
    ECFD_ST_STOP = 2'b00,
    ECFD_ST_WAIT_LOAD = 2'b01,
    ECFD_ST_RUN = 2'b10
  } ecfd_state_e;

endpackage : ecfd_pkg

// ---- hw/ecfd_prescaler.sv ----
// Prescaler producing one-cycle operating clock enables from the system clock.
// Assumes a synchronous enable that clears the dividers when the unit is off.
module ecfd_prescaler
  import ecfd_pkg::*;
#(
  parameter int unsigned W = ECFD_PRESC_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic unit_en_i,
  input wire logic [W-1:0] div_a_i,
  input wire logic [W-1:0] div_b_i,
  output logic tick_a_o,
  output logic tick_b_o
);

  logic [W-1:0] cnt_a_reg;
  logic [W-1:0] cnt_a_next;
  logic [W-1:0] cnt_b_reg;
  logic [W-1:0] cnt_b_next;

  // Tick when the down counter hits zero, then reload the divide value
  always_comb begin
    tick_a_o = unit_en_i && (cnt_a_reg == '0);
    tick_b_o = unit_en_i && (cnt_b_reg == '0);
    cnt_a_next = cnt_a_reg - W'(1);
    cnt_b_next = cnt_b_reg - W'(1);
    if (!unit_en_i) begin
      cnt_a_next = '0;
      cnt_b_next = '0;
    end else begin
      if (tick_a_o) begin
        cnt_a_next = div_a_i;
      end
      if (tick_b_o) begin
        cnt_b_next = div_b_i;
      end
    end
  end

  // Divider registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_a_reg <= ECFD_PRESC_A_RST;
      cnt_b_reg <= ECFD_PRESC_B_RST;
    end else begin
      cnt_a_reg <= cnt_a_next;
      cnt_b_reg <= cnt_b_next;
    end
  end

endmodule : ecfd_prescaler

// ---- hw/ecfd_channel.sv ----
// One timer array channel: external event counter and frequency divider modes.
// Assumes all inputs are synchronous to CLOCK_I and the event pin is pre-synchronised.
module ecfd_channel
  import ecfd_pkg::*;
#(
  parameter int unsigned CHANNEL = 0,
  parameter int unsigned PRESC_W = ECFD_PRESC_W
) (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic UNIT_CLOCK_ENABLE_I,
  input wire logic [PRESC_W-1:0] PRESCALER_SELECT_A_I,
  input wire logic [PRESC_W-1:0] PRESCALER_SELECT_B_I,
  input wire logic CLOCK_SELECT_I,
  input wire logic MODE_DIVIDE_I,
  input wire logic [1:0] EDGE_SELECT_I,
  input wire logic START_INTERRUPT_MODE_BIT_I,
  input wire logic HALF_WIDTH_SELECT_I,
  input wire logic INPUT_FILTER_ENABLE_I,
  input wire logic CHANNEL_START_TRIGGER_I,
  input wire logic CHANNEL_STOP_TRIGGER_I,
  input wire logic DATA_WRITE_I,
  input wire logic [ECFD_CNT_W-1:0] DATA_WDATA_I,
  input wire logic OUTPUT_BIT_WRITE_I,
  input wire logic OUTPUT_BIT_WDATA_I,
  input wire logic OUTPUT_ENABLE_BIT_I,
  input wire logic EVENT_INPUT_PIN_I,
  output logic CHANNEL_ENABLE_STATUS_O,
  output logic [ECFD_CNT_W-1:0] CHANNEL_COUNTER_O,
  output logic [ECFD_CNT_W-1:0] CHANNEL_DATA_VALUE_O,
  output logic OUTPUT_BIT_O,
  output logic TIMER_OUTPUT_PIN_O,
  output logic CHANNEL_INTERRUPT_O
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam bit DIV_OK = (CHANNEL == 0) || (CHANNEL == 3);

  logic tick_a;
  logic tick_b;
  logic op_tick;
  logic unit_on;
  logic divide_mode;
  logic edge_seen;

  ecfd_state_e state_reg;
  ecfd_state_e state_next;
  logic [ECFD_CNT_W-1:0] cnt_reg;
  logic [ECFD_CNT_W-1:0] cnt_next;
  logic [ECFD_CNT_W-1:0] data_reg;
  logic [ECFD_CNT_W-1:0] data_next;
  logic out_bit_reg;
  logic out_bit_next;
  logic irq_reg;
  logic irq_next;
  logic samp_reg;
  logic samp_next;
  logic prev_reg;
  logic prev_next;
  logic filt_reg;
  logic filt_next;

  // Valid edge from current and previous sample
  function automatic logic edge_detect(input logic cur, input logic prev, input logic [1:0] sel);
    logic rise;
    logic fall;
    rise = cur && !prev;
    fall = !cur && prev;
    case (sel)
      ECFD_EDGE_FALL: edge_detect = fall;
      ECFD_EDGE_RISE: edge_detect = rise;
      ECFD_EDGE_BOTH: edge_detect = rise || fall;
      default: edge_detect = rise;
    endcase
  endfunction : edge_detect

  // Zero test on the active counter width; split channels count on the lower half only
  function automatic logic at_zero(input logic [ECFD_CNT_W-1:0] c, input logic half);
    if (half) begin
      at_zero = (c[7:0] == ECFD_HALF_ZERO);
    end else begin
      at_zero = (c == ECFD_CNT_ZERO);
    end
  endfunction : at_zero

  // ****************************************
  // Operating clock selection
  // ****************************************
  ecfd_prescaler #(
    .W(PRESC_W)
  ) u_presc (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .unit_en_i(UNIT_CLOCK_ENABLE_I),
    .div_a_i(PRESCALER_SELECT_A_I),
    .div_b_i(PRESCALER_SELECT_B_I),
    .tick_a_o(tick_a),
    .tick_b_o(tick_b)
  );

  // Per channel choice of op_clock_a or op_clock_b
  assign op_tick = CLOCK_SELECT_I ? tick_b : tick_a; // RULE_03
  assign unit_on = UNIT_CLOCK_ENABLE_I;
  assign divide_mode = MODE_DIVIDE_I && DIV_OK; // RULE_13

  // ****************************************
  // Input sampling and edge detection
  // ****************************************
  // Sample pin on the operating clock; filter needs two equal samples
  always_comb begin
    samp_next = samp_reg;
    prev_next = prev_reg;
    filt_next = filt_reg;
    if (!unit_on) begin
      samp_next = 1'b0;
      prev_next = 1'b0;
      filt_next = 1'b0;
    end else if (op_tick) begin
      samp_next = EVENT_INPUT_PIN_I; // RULE_23
      prev_next = filt_reg; // RULE_25
      if (!INPUT_FILTER_ENABLE_I || (samp_reg == EVENT_INPUT_PIN_I)) begin
        filt_next = INPUT_FILTER_ENABLE_I ? samp_reg : EVENT_INPUT_PIN_I;
      end
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      samp_reg <= 1'b0;
      prev_reg <= 1'b0;
      filt_reg <= 1'b0;
    end else begin
      samp_reg <= samp_next;
      prev_reg <= prev_next;
      filt_reg <= filt_next;
    end
  end

  // Edge is judged once per operating clock, between filtered and previous sample
  assign edge_seen = op_tick && edge_detect(filt_reg, prev_reg, EDGE_SELECT_I); // RULE_25

  // ****************************************
  // Channel control and counter
  // ****************************************
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    data_next = data_reg;
    out_bit_next = out_bit_reg;
    irq_next = 1'b0;
    if (!unit_on) begin
      // Disabled unit: writes blocked and everything back to reset values
      state_next = ECFD_ST_STOP; // RULE_02
      cnt_next = ECFD_CNT_RST; // RULE_02
      data_next = ECFD_DATA_RST; // RULE_01
      out_bit_next = 1'b0;
    end else begin
      if (DATA_WRITE_I) begin
        data_next = DATA_WDATA_I; // RULE_12
      end
      // Output bit write always lands; while enabled, counting toggles win
      if (OUTPUT_BIT_WRITE_I) begin
        out_bit_next = OUTPUT_BIT_WDATA_I; // RULE_21
      end
      case (state_reg)
        ECFD_ST_STOP: begin
          if (CHANNEL_START_TRIGGER_I) begin
            if (divide_mode) begin
              state_next = ECFD_ST_WAIT_LOAD; // RULE_14
            end else begin
              cnt_next = data_reg; // RULE_07
              state_next = ECFD_ST_RUN; // RULE_05
            end
          end
        end
        ECFD_ST_WAIT_LOAD: begin
          if (CHANNEL_STOP_TRIGGER_I) begin
            state_next = ECFD_ST_STOP; // RULE_06
          end else if (edge_seen) begin
            cnt_next = data_reg; // RULE_14
            state_next = ECFD_ST_RUN;
            if (START_INTERRUPT_MODE_BIT_I) begin
              irq_next = 1'b1; // RULE_15
              if (OUTPUT_ENABLE_BIT_I) begin
                out_bit_next = !out_bit_reg; // RULE_15
              end
            end
          end
        end
        ECFD_ST_RUN: begin
          if (CHANNEL_STOP_TRIGGER_I) begin
            state_next = ECFD_ST_STOP; // RULE_06 RULE_20
          end else if (edge_seen) begin
            if (at_zero(cnt_reg, HALF_WIDTH_SELECT_I)) begin
              cnt_next = data_reg; // RULE_08 RULE_16 RULE_24
              irq_next = 1'b1; // RULE_09 RULE_17
              if (divide_mode && OUTPUT_ENABLE_BIT_I) begin
                out_bit_next = !out_bit_reg; // RULE_16 RULE_18 RULE_19
              end
            end else if (HALF_WIDTH_SELECT_I) begin
              cnt_next = {cnt_reg[15:8], cnt_reg[7:0] - 8'h01}; // RULE_24
            end else begin
              cnt_next = cnt_reg - 16'h0001; // RULE_08 RULE_16
            end
          end
        end
        default: begin
          state_next = ECFD_ST_STOP;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg <= ECFD_ST_STOP;
      cnt_reg <= ECFD_CNT_RST;
      data_reg <= ECFD_DATA_RST;
      out_bit_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      data_reg <= data_next;
      out_bit_reg <= out_bit_next;
      irq_reg <= irq_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Status is high in any active state; while the unit is off, reads show reset values (counter 16'hffff, data and status zero)
  assign CHANNEL_ENABLE_STATUS_O = (state_reg != ECFD_ST_STOP); // RULE_05 RULE_26
  assign CHANNEL_COUNTER_O = cnt_reg; // RULE_01
  assign CHANNEL_DATA_VALUE_O = data_reg;
  assign OUTPUT_BIT_O = out_bit_reg;
  assign TIMER_OUTPUT_PIN_O = out_bit_reg; // RULE_19 RULE_20
  assign CHANNEL_INTERRUPT_O = irq_reg;

endmodule : ecfd_channel

// ---- testbench/ecfd_channel_props.sv ----
// Port checker for one edge counter / divider channel.
// Assumes one clock domain and inputs that change just after rising edges.
module ecfd_channel_props
  import ecfd_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic UNIT_CLOCK_ENABLE_I,
  input wire logic MODE_DIVIDE_I,
  input wire logic CHANNEL_START_TRIGGER_I,
  input wire logic CHANNEL_STOP_TRIGGER_I,
  input wire logic DATA_WRITE_I,
  input wire logic OUTPUT_ENABLE_BIT_I,
  input wire logic CHANNEL_ENABLE_STATUS_O,
  input wire logic [ECFD_CNT_W-1:0] CHANNEL_COUNTER_O,
  input wire logic [ECFD_CNT_W-1:0] CHANNEL_DATA_VALUE_O,
  input wire logic OUTPUT_BIT_O,
  input wire logic TIMER_OUTPUT_PIN_O,
  input wire logic CHANNEL_INTERRUPT_O
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // Short aliases and the accepted start condition
  // ****
  wire logic en = UNIT_CLOCK_ENABLE_I;
  wire logic st = CHANNEL_ENABLE_STATUS_O;
  wire logic irq = CHANNEL_INTERRUPT_O;
  wire logic [15:0] cnt = CHANNEL_COUNTER_O;
  wire logic go = CHANNEL_START_TRIGGER_I && en && !st && !CHANNEL_STOP_TRIGGER_I;
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  // Stopped channel with no start pending
  sequence s_idle;
    !st && !CHANNEL_START_TRIGGER_I && en;
  endsequence
  // Event mode start without a data write beside it
  sequence s_go_ev;
    go && !MODE_DIVIDE_I && !DATA_WRITE_I;
  endsequence
  property p_start; go |=> st; endproperty
  property p_stop; CHANNEL_STOP_TRIGGER_I && en |=> !st; endproperty
  property p_hold; s_idle ##1 en |-> $stable(cnt); endproperty
  property p_off; !en |=> !st && cnt == ECFD_CNT_RST && CHANNEL_DATA_VALUE_O == ECFD_DATA_RST
    && !OUTPUT_BIT_O; endproperty
  property p_ev_load; s_go_ev |=> cnt == $past(CHANNEL_DATA_VALUE_O); endproperty
  property p_div_wait; go && MODE_DIVIDE_I |=> $stable(cnt); endproperty
  property p_irq_pulse; irq |=> !irq; endproperty
  property p_irq_reload; irq |-> cnt == $past(CHANNEL_DATA_VALUE_O); endproperty
  property p_toggle; irq && $past(MODE_DIVIDE_I) && $past(OUTPUT_ENABLE_BIT_I) |->
    OUTPUT_BIT_O != $past(OUTPUT_BIT_O);
  endproperty
  property p_pin; TIMER_OUTPUT_PIN_O == OUTPUT_BIT_O; endproperty
  a_start: assert property (p_start) else $error("start did not set status");
  a_stop: assert property (p_stop) else $error("stop did not clear status");
  a_hold: assert property (p_hold) else $error("counter moved while stopped");
  a_off: assert property (p_off) else $error("unit disable did not reset");
  a_ev_load: assert property (p_ev_load) else $error("start did not load data");
  a_div_wait: assert property (p_div_wait) else $error("divider loaded at start");
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt too long");
  a_irq_reload: assert property (p_irq_reload) else $error("no reload with irq");
  a_toggle: assert property (p_toggle) else $error("no toggle with irq");
  a_pin: assert property (p_pin) else $error("pin differs from output bit");
endmodule : ecfd_channel_props

bind ecfd_channel ecfd_channel_props ecfd_channel_props_inst (.*);

// ---- testbench/ecfd_edge_src.sv ----
// Edge source model for the event input pin.
// Assumes the bench asks for edges only between its checks.
module ecfd_edge_src (
  input wire logic clk_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial pin_o = 1'h0;
  // Toggle n times, holding each level long enough to be sampled
  task automatic toggle(input int n, input int gap);
    repeat (n) begin
      @(posedge clk_i);
      pin_o <= ~pin_o;
      repeat (gap) @(posedge clk_i);
    end
  endtask : toggle
endmodule : ecfd_edge_src

// ---- testbench/ecfd_channel_tb.sv ----
// Self-checking bench for channel 0 in event and divider modes.
// Assumes the checker is bound to the channel and prescaler a ticks every clock.
module ecfd_channel_tb
  import ecfd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = '0, rst = '1, en = '0, csel = '0, mdiv = '0, sim = '0, flt = '0, hws = '0;
  logic go = '0, stp = '0, dw = '0, ow = '0, owd = '0, oe = '0, st, ob, tp, irq, pin;
  logic [1:0] edg = ECFD_EDGE_RISE;
  logic [15:0] wd = '0, cnt, dat, nirq = '0;
  int err_total = 0, n_checks = 0, gap = 6;
  always #5 clk = ~clk;
  // Interrupt pulse counter
  always @(posedge clk) if (irq === 1'h1) nirq <= nirq + 16'h1;
  ecfd_channel #(.CHANNEL(0)) ecfd_channel_inst (.CLOCK_I(clk), .RST_I(rst),
    .UNIT_CLOCK_ENABLE_I(en), .PRESCALER_SELECT_A_I(16'h0000), .PRESCALER_SELECT_B_I(16'h00c7),
    .CLOCK_SELECT_I(csel), .MODE_DIVIDE_I(mdiv), .EDGE_SELECT_I(edg),
    .START_INTERRUPT_MODE_BIT_I(sim), .HALF_WIDTH_SELECT_I(hws), .INPUT_FILTER_ENABLE_I(flt),
    .CHANNEL_START_TRIGGER_I(go), .CHANNEL_STOP_TRIGGER_I(stp), .DATA_WRITE_I(dw),
    .DATA_WDATA_I(wd), .OUTPUT_BIT_WRITE_I(ow), .OUTPUT_BIT_WDATA_I(owd),
    .OUTPUT_ENABLE_BIT_I(oe), .EVENT_INPUT_PIN_I(pin), .CHANNEL_ENABLE_STATUS_O(st),
    .CHANNEL_COUNTER_O(cnt), .CHANNEL_DATA_VALUE_O(dat), .OUTPUT_BIT_O(ob),
    .TIMER_OUTPUT_PIN_O(tp), .CHANNEL_INTERRUPT_O(irq));
  ecfd_edge_src ecfd_edge_src_inst (.clk_i(clk), .pin_o(pin));
  // ****
  // Access tasks
  // ****
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // One-cycle pulse: 0 start, 1 stop, 2 data write, 3 output bit write
  task automatic pul(input int k, input logic [15:0] d = '0);
    @(posedge clk);
    case (k)
      0: go <= 1'h1;
      1: stp <= 1'h1;
      2: dw <= 1'h1;
      default: ow <= 1'h1;
    endcase
    wd <= d;
    owd <= d[0];
    @(posedge clk);
    {go, stp, dw, ow} <= '0;
    tick(1);
  endtask : pul
  // Send n valid edges for the present edge selection
  task automatic ev(input int n);
    ecfd_edge_src_inst.toggle(edg == ECFD_EDGE_BOTH ? n : 2 * n, gap);
    tick(gap);
  endtask : ev
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end
  // ****
  // Test sequence
  // ****
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    // Writes ignored while the unit is off
    pul(2, 16'h0005);
    chk("data", ECFD_DATA_RST, dat);
    chk("count", ECFD_CNT_RST, cnt);
    @(posedge clk) en <= 1'h1;
    tick(1);
    chk("status", 16'h0, {15'h0, st});
    pul(3, 16'h0000);
    // Event counter: load, count down, rewrite data mid-period, reload
    pul(2, 16'h0002);
    pul(0);
    chk("status", 16'h1, {15'h0, st});
    chk("count", 16'h0002, cnt);
    pul(2, 16'h0004);
    chk("count", 16'h0002, cnt);
    ev(2);
    chk("count", 16'h0000, cnt);
    chk("irq", 16'h0, nirq);
    ev(1);
    chk("count", 16'h0004, cnt);
    chk("irq", 16'h1, nirq);
    chk("pin", 16'h0, {15'h0, tp});
    pul(1);
    ev(1);
    chk("status", 16'h0, {15'h0, st});
    chk("count", 16'h0004, cnt);
    // Each edge code with data zero gives one interrupt per edge
    pul(2, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      @(posedge clk) edg <= c[1:0];
      pul(0);
      ev(1);
      pul(1);
      chk("irq", 16'h2 + c[15:0], nirq);
    end
    // Slow operating clock b with the filter on; pin idles high, so count falls
    @(posedge clk) {csel, edg} <= {1'h1, ECFD_EDGE_FALL};
    @(posedge clk) flt <= 1'h1;
    pul(0);
    ecfd_edge_src_inst.toggle(1, 20);
    chk("irq", 16'h5, nirq);
    tick(1000);
    chk("irq", 16'h6, nirq);
    ecfd_edge_src_inst.toggle(1, 1000);
    pul(1);
    @(posedge clk) csel <= 1'h0;
    pul(2, 16'h0009);
    // Unit disable resets, then divider on both edges with data one
    @(posedge clk) en <= 1'h0;
    @(posedge clk) en <= 1'h1;
    tick(1);
    chk("data", ECFD_DATA_RST, dat);
    chk("count", ECFD_CNT_RST, cnt);
    @(posedge clk) {mdiv, oe, edg} <= {2'h3, ECFD_EDGE_BOTH};
    pul(2, 16'h0001);
    pul(0);
    chk("count", ECFD_CNT_RST, cnt);
    ev(1);
    chk("count", 16'h0001, cnt);
    chk("irq", 16'h6, nirq);
    chk("pin", 16'h0, {15'h0, tp});
    ev(2);
    chk("pin", 16'h1, {15'h0, tp});
    chk("irq", 16'h7, nirq);
    ev(2);
    chk("pin", 16'h0, {15'h0, tp});
    ev(2);
    pul(1);
    ev(2);
    chk("pin", 16'h1, {15'h0, tp});
    @(posedge clk) oe <= 1'h0;
    pul(3, 16'h0000);
    chk("pin", 16'h0, {15'h0, tp});
    chk("outbit", 16'h0, {15'h0, ob});
    // Start interrupt mode one: first load interrupts and toggles
    @(posedge clk) {sim, oe} <= 2'h3;
    pul(0);
    ev(1);
    chk("pin", 16'h1, {15'h0, tp});
    chk("irq", 16'ha, nirq);
    // Split event counter: only the low byte counts, upper byte held
    pul(1);
    @(posedge clk) {mdiv, sim, oe, hws} <= 4'h1;
    pul(2, 16'h0301);
    pul(0);
    ev(1);
    chk("count", 16'h0300, cnt);
    ev(1);
    chk("count", 16'h0301, cnt);
    chk("irq", 16'hb, nirq);
    print_verdict();
  end
endmodule : ecfd_channel_tb
